// file: rtl/fsrg_map.svh
// Behaviour
// - A detected fault sets its status bit, which stays set until cleared.
// - Every output fault status bit stays set until written with 1.
// - A cleared bit sets again while its fault persists or returns.
// - Protected configuration is rechecked every 5 ms; a change sets the check fault.
// - With matching reference checksum the check fault still sets but shuts nothing down.
// - A cleared check fault sets again within one 5 ms recheck interval.
// - Output fault with response disabled shuts nothing down; status still recorded.
// - Enabled response shuts the output down, then applies retry or latch-off policy.
// - Response masks accept writes whenever main enable is not off.
// - High-voltage latch-off sets a flag blocking restart; clearing it releases.
// - Low-voltage latch-off sets a flag blocking all low-voltage outputs until cleared.
// - A routed fault pulls the pin low while detected; unrouted faults leave it.
// - Routing is writable in standby and on and is outside the checksum.
// - Pin control bit 7 returns the live pin level in either direction.
// - As plain logic output, write data 1 releases the pin, 0 pulls low.
// - The pin is open-drain in every output function.
// - Pin function resets to option 1: released during init, low afterwards.
// - Input direction overrides every function and leaves the pin undriven.
// - Watchdog, compare, bus checksum, check and sequencer faults are individually sticky.
// - Policy 0 retries forever, 1 ten times, 2 five times, 3 latches at once.
`ifndef FSRG_MAP_SVH
`define FSRG_MAP_SVH

// ==========================================================================
// Register offsets
`define FSRG_ADDR_MISC1 8'h7b
`define FSRG_ADDR_REF_LO 8'h7e
`define FSRG_ADDR_REF_HI 8'h7f
`define FSRG_ADDR_STAT_BASE 8'h80
`define FSRG_ADDR_GSTAT 8'h84
`define FSRG_ADDR_MASK_BASE 8'h88
`define FSRG_ADDR_GMASK 8'h8c
`define FSRG_ADDR_ROUTE_BASE 8'h90
`define FSRG_ADDR_GROUTE 8'h94
`define FSRG_ADDR_LATCH 8'h98
`define FSRG_ADDR_PIN_CTRL 8'ha4
`define FSRG_ADDR_CRC_LO 8'hb6
`define FSRG_ADDR_CRC_HI 8'hb7

// ==========================================================================
// Field positions and reset values
`define FSRG_MISC1_POLICY_LSB 6
`define FSRG_PIN_LEVEL_BIT 7
`define FSRG_PIN_DIR_BIT 6
`define FSRG_PIN_WDATA_BIT 5
`define FSRG_PIN_FUNC_LSB 0
`define FSRG_PIN_FUNC_RESET 3'h1
`define FSRG_PIN_WDATA_RESET 1'h1
`define FSRG_GLOB_CRC_BIT 5
`define FSRG_RETRY_TEN 4'h9
`define FSRG_RETRY_FIVE 4'h4

// ==========================================================================
// Timing
`define FSRG_RECHECK_MS 5
`define FSRG_CLK_KHZ 20000
`define FSRG_RECHECK_CYCLES (`FSRG_RECHECK_MS * `FSRG_CLK_KHZ)

`endif

// file: rtl/fsrg_pkg.sv
package fsrg_pkg;
  typedef enum logic [1:0] {
    FSRG_EN_OFF = 2'h0,
    FSRG_EN_STANDBY = 2'h1,
    FSRG_EN_ON = 2'h2
  } fsrg_en_t;

  typedef enum logic [2:0] {
    FSRG_FUNC_LOGIC = 3'h0,
    FSRG_FUNC_INIT = 3'h1,
    FSRG_FUNC_FAULT = 3'h2
  } fsrg_func_t;

  typedef enum logic [1:0] {
    FSRG_POL_FOREVER = 2'h0,
    FSRG_POL_TEN = 2'h1,
    FSRG_POL_FIVE = 2'h2,
    FSRG_POL_FIRST = 2'h3
  } fsrg_pol_t;

  typedef struct packed {
    logic [31:0] det_prev;
    logic [5:0] gdet_prev;
    logic [3:0][7:0] mask;
    logic [6:0] gmask;
    logic [3:0][7:0] route;
    logic [6:0] groute;
    logic [1:0] policy;
    logic [15:0] ref_crc;
    logic pin_dir;
    logic pin_wdata;
    logic [2:0] pin_func;
    logic [16:0] timer;
    logic [3:0] retry_hv;
    logic [3:0] retry_lv;
    logic [7:0] rdata;
    logic hv_sd;
    logic lv_sd;
  } fsrg_state_t;
endpackage : fsrg_pkg

// file: rtl/fsrg_sync.sv
`timescale 1ns/1ps
module fsrg_sync #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fsrg_sync_t;

  fsrg_sync_t st_q;
  fsrg_sync_t st_d;

  always_comb begin
    st_d.s1 = d_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.s2;
endmodule : fsrg_sync

// file: rtl/fsrg_sticky.sv
`timescale 1ns/1ps
module fsrg_sticky #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] flag;
  } fsrg_sticky_t;

  fsrg_sticky_t st_q;
  fsrg_sticky_t st_d;

  always_comb begin
    st_d.flag = (st_q.flag & ~clr_in) | set_in;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.flag;
endmodule : fsrg_sticky

// file: rtl/fsrg_top.sv
`timescale 1ns/1ps
`include "fsrg_map.svh"
module fsrg_top
  import fsrg_pkg::*;
#(
  parameter logic [16:0] RECHECK_CYCLES = 17'(`FSRG_RECHECK_CYCLES),
  parameter logic [15:0] FACTORY_CRC = 16'h0000
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [31:0] fault_det_in,
  input wire logic [5:0] glob_det_in,
  input wire logic [1:0] en_state_in,
  input wire logic init_done_in,
  input wire logic [15:0] config_crc_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n_out,
  output logic hv_shutdown_out,
  output logic lv_shutdown_out,
  output logic hv_latched_out,
  output logic lv_latched_out
);
  // ========================================================================
  // Input synchronisers
  logic [40:0] sync_q;
  logic [31:0] det;
  logic [5:0] gdet;
  fsrg_en_t en_s;
  logic pin_s;

  fsrg_sync #(.W(41)) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .d_in({pin_in, en_state_in, glob_det_in, fault_det_in}),
    .q_out(sync_q)
  );

  assign det = sync_q[31:0];
  assign gdet = sync_q[37:32];
  assign en_s = fsrg_en_t'(sync_q[39:38]);
  assign pin_s = sync_q[40];

  // ========================================================================
  // Sticky flags
  fsrg_state_t st_q;
  fsrg_state_t st_d;
  logic [31:0] stat;
  logic [31:0] stat_clr;
  logic [6:0] gstat;
  logic [6:0] gstat_set;
  logic [6:0] gstat_clr;
  logic [1:0] latch;
  logic [1:0] latch_set;
  logic [1:0] latch_clr;
  logic tick;
  logic crc_mismatch;
  logic wr_ok_active;
  logic wr_standby;

  assign tick = (st_q.timer == 17'h0);
  assign crc_mismatch = (config_crc_in != FACTORY_CRC);
  // Watchdog, compare and bus checksum keep bits 0..4, sequencer bit 6.
  assign gstat_set = {gdet[5], tick & crc_mismatch, gdet[4:0]};

  fsrg_sticky #(.W(32)) u_stat (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(det),
    .clr_in(stat_clr),
    .q_out(stat)
  );

  fsrg_sticky #(.W(7)) u_gstat (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(gstat_set),
    .clr_in(gstat_clr),
    .q_out(gstat)
  );

  fsrg_sticky #(.W(2)) u_latch (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(latch_set),
    .clr_in(latch_clr),
    .q_out(latch)
  );

  // ========================================================================
  // Register writes and clears
  assign wr_ok_active = reg_wr_in && (en_s != FSRG_EN_OFF);
  assign wr_standby = reg_wr_in && (en_s == FSRG_EN_STANDBY);

  always_comb begin
    stat_clr = '0;
    for (int i = 0; i < 4; i++) begin
      if (reg_wr_in && reg_addr_in == (`FSRG_ADDR_STAT_BASE + 8'(i))) begin
        stat_clr[i*8 +: 8] = reg_wdata_in;
      end
    end
    gstat_clr = (reg_wr_in && reg_addr_in == `FSRG_ADDR_GSTAT) ? reg_wdata_in[6:0] : 7'h0;
    latch_clr = (reg_wr_in && reg_addr_in == `FSRG_ADDR_LATCH) ? reg_wdata_in[1:0] : 2'h0;
  end

  // ========================================================================
  // Fault response and retry policy
  logic [31:0] det_rise;
  logic [5:0] gdet_rise;
  logic [31:0] mask_flat;
  logic [31:0] route_flat;
  logic glob_resp;
  logic crc_resp;
  logic hv_resp;
  logic lv_resp;
  logic hv_limit;
  logic lv_limit;
  logic pull_low;

  assign mask_flat = st_q.mask;
  assign route_flat = st_q.route;
  assign det_rise = det & ~st_q.det_prev;
  assign gdet_rise = gdet & ~st_q.gdet_prev;
  // A checksum that matches the reference is tolerated: flagged, never acted on.
  assign crc_resp = tick && crc_mismatch && (config_crc_in != st_q.ref_crc)
                    && st_q.gmask[`FSRG_GLOB_CRC_BIT];
  assign glob_resp = (|({gdet_rise[5], 1'b0, gdet_rise[4:0]} & st_q.gmask)) || crc_resp;
  assign hv_resp = (|(det_rise[7:0] & mask_flat[7:0])) || glob_resp;
  assign lv_resp = (|(det_rise[31:8] & mask_flat[31:8])) || glob_resp;

  function automatic logic fsrg_limit(input logic [1:0] pol, input logic [3:0] cnt);
    logic hit;
    hit = 1'b0;
    unique case (fsrg_pol_t'(pol))
      FSRG_POL_FOREVER: hit = 1'b0;
      FSRG_POL_TEN: hit = (cnt >= `FSRG_RETRY_TEN);
      FSRG_POL_FIVE: hit = (cnt >= `FSRG_RETRY_FIVE);
      FSRG_POL_FIRST: hit = 1'b1;
    endcase
    return hit;
  endfunction : fsrg_limit

  assign hv_limit = fsrg_limit(st_q.policy, st_q.retry_hv);
  assign lv_limit = fsrg_limit(st_q.policy, st_q.retry_lv);
  assign latch_set = {lv_resp && lv_limit, hv_resp && hv_limit};

  // ========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.det_prev = det;
    st_d.gdet_prev = gdet;
    st_d.timer = tick ? RECHECK_CYCLES - 17'h1 : st_q.timer - 17'h1;
    st_d.hv_sd = hv_resp && !latch[0];
    st_d.lv_sd = lv_resp && !latch[1];
    if (latch_clr[0]) begin
      st_d.retry_hv = 4'h0;
    end else if (hv_resp && !hv_limit && st_q.retry_hv != 4'hf) begin
      st_d.retry_hv = st_q.retry_hv + 4'h1;
    end
    if (latch_clr[1]) begin
      st_d.retry_lv = 4'h0;
    end else if (lv_resp && !lv_limit && st_q.retry_lv != 4'hf) begin
      st_d.retry_lv = st_q.retry_lv + 4'h1;
    end
    for (int i = 0; i < 4; i++) begin
      if (wr_ok_active && reg_addr_in == (`FSRG_ADDR_MASK_BASE + 8'(i))) begin
        st_d.mask[i] = reg_wdata_in;
      end
      if (wr_ok_active && reg_addr_in == (`FSRG_ADDR_ROUTE_BASE + 8'(i))) begin
        st_d.route[i] = reg_wdata_in;
      end
    end
    if (wr_ok_active && reg_addr_in == `FSRG_ADDR_GMASK) begin
      st_d.gmask = reg_wdata_in[6:0];
    end
    if (wr_ok_active && reg_addr_in == `FSRG_ADDR_GROUTE) begin
      st_d.groute = reg_wdata_in[6:0];
    end
    // Checksum-protected settings only change in standby.
    if (wr_standby && reg_addr_in == `FSRG_ADDR_MISC1) begin
      st_d.policy = reg_wdata_in[`FSRG_MISC1_POLICY_LSB +: 2];
    end
    if (wr_standby && reg_addr_in == `FSRG_ADDR_REF_LO) begin
      st_d.ref_crc[7:0] = reg_wdata_in;
    end
    if (wr_standby && reg_addr_in == `FSRG_ADDR_REF_HI) begin
      st_d.ref_crc[15:8] = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == `FSRG_ADDR_PIN_CTRL) begin
      st_d.pin_dir = reg_wdata_in[`FSRG_PIN_DIR_BIT];
      st_d.pin_wdata = reg_wdata_in[`FSRG_PIN_WDATA_BIT];
      st_d.pin_func = reg_wdata_in[`FSRG_PIN_FUNC_LSB +: 3];
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `FSRG_ADDR_MISC1: st_d.rdata = {st_q.policy, 6'h0};
        `FSRG_ADDR_REF_LO: st_d.rdata = st_q.ref_crc[7:0];
        `FSRG_ADDR_REF_HI: st_d.rdata = st_q.ref_crc[15:8];
        8'h80, 8'h81, 8'h82, 8'h83: st_d.rdata = stat[reg_addr_in[1:0]*8 +: 8];
        `FSRG_ADDR_GSTAT: st_d.rdata = {1'b0, gstat};
        8'h88, 8'h89, 8'h8a, 8'h8b: st_d.rdata = st_q.mask[reg_addr_in[1:0]];
        `FSRG_ADDR_GMASK: st_d.rdata = {1'b0, st_q.gmask};
        8'h90, 8'h91, 8'h92, 8'h93: st_d.rdata = st_q.route[reg_addr_in[1:0]];
        `FSRG_ADDR_GROUTE: st_d.rdata = {1'b0, st_q.groute};
        `FSRG_ADDR_LATCH: st_d.rdata = {6'h0, latch};
        `FSRG_ADDR_PIN_CTRL: st_d.rdata = {pin_s, st_q.pin_dir, st_q.pin_wdata,
                                           2'h0, st_q.pin_func};
        `FSRG_ADDR_CRC_LO: st_d.rdata = config_crc_in[7:0];
        `FSRG_ADDR_CRC_HI: st_d.rdata = config_crc_in[15:8];
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
      st_q.pin_func <= `FSRG_PIN_FUNC_RESET;
      st_q.pin_wdata <= `FSRG_PIN_WDATA_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Open-drain pin
  always_comb begin
    pull_low = 1'b0;
    if (!st_q.pin_dir) begin
      unique case (st_q.pin_func)
        FSRG_FUNC_LOGIC: pull_low = !st_q.pin_wdata;
        FSRG_FUNC_INIT: pull_low = init_done_in;
        // Live detections, not sticky bits, so the pin follows the fault itself.
        FSRG_FUNC_FAULT: pull_low = (|(det & route_flat))
                                    || (|(gstat_set & st_q.groute));
        default: pull_low = 1'b0;
      endcase
    end
  end

  assign pin_out = 1'b0;
  assign pin_oe_n_out = !pull_low;
  assign reg_rdata_out = st_q.rdata;
  assign hv_shutdown_out = st_q.hv_sd;
  assign lv_shutdown_out = st_q.lv_sd;
  assign hv_latched_out = latch[0];
  assign lv_latched_out = latch[1];
endmodule : fsrg_top

// file: tb/fsrg_top_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Pin and latch-off checks
module fsrg_top_asserts (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic init_done_in,
  input wire logic pin_out,
  input wire logic pin_oe_n_out,
  input wire logic hv_shutdown_out,
  input wire logic lv_shutdown_out,
  input wire logic hv_latched_out,
  input wire logic lv_latched_out
);
  logic seen_q;
  logic armed_q;
  logic [7:0] pin_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // A refused mask write still arms, so the masked-off check can only err on the lenient side.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      seen_q <= 1'b0;
      armed_q <= 1'b0;
      pin_q <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'ha4) begin
        seen_q <= 1'b1;
        pin_q <= reg_wdata_in;
      end
      if (reg_addr_in[7:3] == 5'h11 && reg_wdata_in != 8'h00) begin
        armed_q <= 1'b1;
      end
    end
  end
  property p_open_drain;
    pin_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  property p_init_func;
    !seen_q |-> pin_oe_n_out == !init_done_in;
  endproperty
  a_init_func: assert property (p_init_func)
    else $error("pin not following initialization");
  property p_input_dir;
    seen_q && pin_q[6] |-> pin_oe_n_out;
  endproperty
  a_input_dir: assert property (p_input_dir)
    else $error("pin driven while input");
  property p_logic_out;
    seen_q && !pin_q[6] && pin_q[2:0] == 3'h0 |-> pin_oe_n_out == pin_q[5];
  endproperty
  a_logic_out: assert property (p_logic_out)
    else $error("pin level differs from write data");
  property p_hv_hold;
    hv_latched_out && !(reg_wr_in && reg_addr_in == 8'h98 && reg_wdata_in[0]) |=> hv_latched_out;
  endproperty
  a_hv_hold: assert property (p_hv_hold)
    else $error("high-voltage latch dropped");
  property p_lv_hold;
    lv_latched_out && !(reg_wr_in && reg_addr_in == 8'h98 && reg_wdata_in[1]) |=> lv_latched_out;
  endproperty
  a_lv_hold: assert property (p_lv_hold)
    else $error("low-voltage latch dropped");
  property p_masked_off;
    !armed_q |-> !hv_shutdown_out && !lv_shutdown_out;
  endproperty
  a_masked_off: assert property (p_masked_off)
    else $error("shutdown with all responses off");
  property p_latched_quiet;
    !(hv_latched_out && $past(hv_latched_out) && hv_shutdown_out) &&
      !(lv_latched_out && $past(lv_latched_out) && lv_shutdown_out);
  endproperty
  a_latched_quiet: assert property (p_latched_quiet)
    else $error("shutdown while latched off");
endmodule : fsrg_top_asserts

bind fsrg_top fsrg_top_asserts u_fsrg_top_asserts (.*);

// file: tb/fsrg_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host register port model
module fsrg_host (
  input wire logic clock_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out = 8'h00,
  output logic [7:0] reg_wdata_out = 8'h00,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0
);
  // Idle lines show the inverse of the last value so stale data is never taken as live.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge clock_in);
    d = reg_rdata_in;
  endtask : rd
endmodule : fsrg_host

// file: tb/fsrg_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin error_cnt++; \
  $display("unexpected at %0t: %h vs %h", $time, g, w); end end
module fsrg_top_tb;
  import fsrg_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic init_done_in = 1'b0;
  logic ext_low = 1'b0;
  logic reg_wr_in, reg_rd_in, pin_out, pin_oe_n_out;
  logic hv_shutdown_out, lv_shutdown_out, hv_latched_out, lv_latched_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_d;
  logic [31:0] fault_det_in = 32'h0;
  logic [5:0] glob_det_in = 6'h0;
  logic [1:0] en_state_in = FSRG_EN_ON;
  logic [15:0] config_crc_in = 16'h0;
  logic [7:0] pin_wr [5] = '{8'h00, 8'h20, 8'h40, 8'h42, 8'h07};
  logic [4:0] pin_ext = 5'h04;
  logic [4:0] pin_oe = 5'h1e;
  int error_cnt, checks_done, hv_cnt, lv_cnt, b, c, k, n;
  int seed = 9536;
  int exp_reg [256];
  wire pin_in = pin_oe_n_out & !ext_low;
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    hv_cnt <= hv_cnt + int'(hv_shutdown_out === 1'b1);
    lv_cnt <= lv_cnt + int'(lv_shutdown_out === 1'b1);
  end
  fsrg_top #(.RECHECK_CYCLES(17'h32)) u_fsrg_top (.*);
  fsrg_host u_fsrg_host (.clock_in(clock_in), .reg_rdata_in(reg_rdata_out),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in));
  // ==========================================================================
  // Helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_fsrg_host.wr(a, d);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a);
    u_fsrg_host.rd(a, rd_d);
    `CHK(rd_d, exp_reg[a][7:0])
  endtask : chk_rd
  task automatic pulse(input int i);
    @(posedge clock_in);
    fault_det_in[i] <= 1'b1;
    repeat (4) @(posedge clock_in);
    fault_det_in[i] <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : pulse
  task automatic set_en(input fsrg_en_t e);
    @(posedge clock_in);
    en_state_in <= e;
    repeat (3) @(posedge clock_in);
  endtask : set_en
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    `CHK(pin_oe_n_out, 1'b1)
    exp_reg['ha4] = 'ha1;
    chk_rd(8'ha4);
    init_done_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    `CHK(pin_oe_n_out, 1'b0)
    exp_reg['ha4] = 'h21;
    chk_rd(8'ha4);
    for (k = 0; k < 5; k++) begin
      wr(8'ha4, pin_wr[k]);
      ext_low <= pin_ext[k];
      repeat (3) @(posedge clock_in);
      `CHK(pin_oe_n_out, pin_oe[k])
      exp_reg['ha4] = {24'h0, pin_oe[k] & !pin_ext[k], pin_wr[k][6:0]};
      chk_rd(8'ha4);
    end
    ext_low <= 1'b0;
    $display("pin test done");
    b = $unsigned($random(seed)) % 8;
    c = (b + 1) % 8;
    pulse(b);
    pulse(c);
    exp_reg['h80] = (1 << b) | (1 << c);
    chk_rd(8'h80);
    wr(8'h80, 8'(1 << b));
    exp_reg['h80] = 1 << c;
    chk_rd(8'h80);
    fault_det_in[c] <= 1'b1;
    repeat (4) @(posedge clock_in);
    wr(8'h80, 8'(1 << c));
    chk_rd(8'h80);
    fault_det_in[c] <= 1'b0;
    repeat (3) @(posedge clock_in);
    wr(8'h80, 8'(1 << c));
    exp_reg['h80] = 0;
    chk_rd(8'h80);
    `CHK(hv_cnt, 0)
    $display("status test done");
    wr(8'h88, 8'(1 << b));
    pulse(b);
    `CHK(hv_cnt, 1)
    `CHK(hv_latched_out, 1'b0)
    set_en(FSRG_EN_STANDBY);
    wr(8'h7b, 8'hc0);
    set_en(FSRG_EN_ON);
    pulse(b);
    pulse(b);
    `CHK(hv_cnt, 2)
    exp_reg['h98] = 1;
    chk_rd(8'h98);
    wr(8'h98, 8'h01);
    exp_reg['h98] = 0;
    chk_rd(8'h98);
    set_en(FSRG_EN_OFF);
    wr(8'h8a, 8'hff);
    set_en(FSRG_EN_STANDBY);
    wr(8'h7b, 8'h80);
    wr(8'h8b, 8'h81);
    exp_reg['h8b] = 'h81;
    chk_rd(8'h8a);
    chk_rd(8'h8b);
    set_en(FSRG_EN_ON);
    for (k = 0; k < 2; k++) begin
      wr(8'h88 + 8'(k), 8'(1 << b));
      for (n = 1; n <= 5; n++) begin
        pulse(8 * k + b);
        `CHK(k ? lv_latched_out : hv_latched_out, n == 5)
      end
    end
    `CHK(hv_cnt, 7)
    `CHK(lv_cnt, 5)
    wr(8'h98, 8'h03);
    chk_rd(8'h98);
    $display("response test done");
    wr(8'ha4, 8'h02);
    wr(8'h92, 8'(1 << b));
    exp_reg['h92] = 1 << b;
    chk_rd(8'h92);
    for (n = 0; n < 2; n++) begin
      fault_det_in[16 + (n ? c : b)] <= 1'b1;
      repeat (4) @(posedge clock_in);
      `CHK(pin_oe_n_out, 1'(n))
      fault_det_in[16 + (n ? c : b)] <= 1'b0;
      repeat (4) @(posedge clock_in);
      `CHK(pin_oe_n_out, 1'b1)
    end
    $display("routing test done");
    glob_det_in[3] <= 1'b1;
    repeat (4) @(posedge clock_in);
    glob_det_in[3] <= 1'b0;
    repeat (3) @(posedge clock_in);
    exp_reg['h84] = 'h08;
    chk_rd(8'h84);
    wr(8'h84, 8'h08);
    exp_reg['h84] = 0;
    chk_rd(8'h84);
    chk_rd(8'h84);
    config_crc_in <= 16'($random(seed)) | 16'h1;
    repeat (52) @(posedge clock_in);
    exp_reg['h84] = 'h20;
    chk_rd(8'h84);
    wr(8'h84, 8'h20);
    repeat (52) @(posedge clock_in);
    chk_rd(8'h84);
    set_en(FSRG_EN_STANDBY);
    wr(8'h7e, config_crc_in[7:0]);
    wr(8'h7f, config_crc_in[15:8]);
    wr(8'h8c, 8'h20);
    set_en(FSRG_EN_ON);
    repeat (110) @(posedge clock_in);
    `CHK(hv_cnt + lv_cnt, 12)
    chk_rd(8'h84);
    $display("checksum test done");
    test_done();
  end
endmodule : fsrg_top_tb
